// ===== core/tcg_pkg.sv
package tcg_pkg;

	// Register byte addresses
	localparam logic [11:0] TCG_ADDR_CTRL   = 12'h000;
	localparam logic [11:0] TCG_ADDR_GATE   = 12'h004;
	localparam logic [11:0] TCG_ADDR_CLKSEL = 12'h008;
	localparam logic [11:0] TCG_ADDR_CNT_LO = 12'h00C;
	localparam logic [11:0] TCG_ADDR_CNT_HI = 12'h010;

	// Control register fields
	localparam int TCG_CTRL_ON_BIT   = 0;
	localparam int TCG_CTRL_WIDE_READ_MODE_BIT = 1;
	localparam int TCG_CTRL_SYNC_BIT = 2;
	localparam int TCG_CTRL_PS_LSB   = 4;
	localparam logic [7:0] TCG_CTRL_MASK = 8'h37;

	// Gate control register fields
	localparam int TCG_GATE_VAL_BIT = 2;
	localparam int TCG_GATE_ARM_BIT = 3;
	localparam int TCG_GATE_SPM_BIT = 4;
	localparam int TCG_GATE_TM_BIT  = 5;
	localparam int TCG_GATE_POL_BIT = 6;
	localparam int TCG_GATE_EN_BIT  = 7;
	localparam logic [7:0] TCG_GATE_MASK = 8'hF8;

	localparam logic [7:0] TCG_CTRL_RESET = 8'h00;
	localparam logic [7:0] TCG_GATE_RESET = 8'h00;

	// Clock source codes that count on the internal clock
	localparam logic [1:0] TCG_SRC_FOSC_DIV4 = 2'h1;
	localparam logic [1:0] TCG_SRC_FOSC      = 2'h2;

	typedef struct packed {
		logic [1:0] input_prescale_select;
		logic       ext_sync_bypass;
		logic       wide_read_mode;
		logic       count_enable;
	} tcg_ctrl_t;

	typedef struct packed {
		logic gate_enable;
		logic gate_polarity;
		logic gate_toggle_mode;
		logic gate_single_pulse_mode;
		logic pulse_arm_status;
	} tcg_gate_t;

endpackage

// ===== core/tcg_sync.sv
`timescale 1ns/1ps
module tcg_sync (
	input  wire logic sys_clk,   // System clock
	input  wire logic reset,     // Async reset, high
	input  wire logic din,       // Asynchronous level
	output logic      dout       // Level in sys_clk domain
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;

	always_comb begin
		meta_d = din;
		sync_d = meta_q;
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign dout = sync_q;
endmodule

// ===== core/tcg_top.sv
// Contract
// - Count-enable runs timer; clear stops, clears toggle
// - Internal clock sources ignore sync bit
// - Two-bit field selects input prescale divider
// - Unimplemented control bits ignore writes, read zero
// - Control bits clear only on POR/BOR
// - Polarity bit selects active-high or active-low gate
// - Toggle mode toggles on gate rise; off clears
// - Pulse arm status cleared when single-pulse mode off
`timescale 1ns/1ps
module tcg_top (
	input  wire logic        sys_clk,     // System clock, 100 MHz
	input  wire logic        reset,       // Async reset, high (POR/BOR)
	input  wire logic        psel,        // APB select
	input  wire logic        penable,     // APB enable
	input  wire logic        pwrite,      // APB direction
	input  wire logic [11:0] paddr,       // APB byte address
	input  wire logic [31:0] pwdata,      // APB write data
	input  wire logic [3:0]  pstrb,       // APB byte strobes
	output logic      [31:0] prdata,      // APB read data
	output logic             pready,      // APB ready
	output logic             pslverr,     // APB error
	input  wire logic        ext_clk_in,  // External count clock
	input  wire logic        gate_in,     // Selected gate source
	output logic      [15:0] count_value, // Counter value
	output logic             gate_level   // Live gate level
);
	localparam int PS_W = 3;

	tcg_pkg::tcg_ctrl_t ctrl_q;
	tcg_pkg::tcg_ctrl_t ctrl_d;
	tcg_pkg::tcg_gate_t gate_q;
	tcg_pkg::tcg_gate_t gate_d;
	logic [1:0]  clock_source_select_q;
	logic [1:0]  clock_source_select_d;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic [7:0]  hi_buf_q;
	logic [7:0]  hi_buf_d;
	logic [PS_W-1:0] ps_q;
	logic [PS_W-1:0] ps_d;
	logic        tick_prev_q;
	logic        tick_prev_d;
	logic        gate_prev_q;
	logic        gate_prev_d;
	logic        tog_q;
	logic        tog_d;
	logic        pulse_prev_q;
	logic        pulse_prev_d;
	logic        pulse_open_q;
	logic        pulse_open_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [1:0]  qdiv_q;
	logic [1:0]  qdiv_d;

	logic        ext_synced;
	logic        timer_clock_source;
	logic        internal_src;
	logic        internal_tick;
	logic        src_edge;
	logic        inc_edge;
	logic        gate_rise;
	logic        gate_pol;
	logic        gate_ctrl;
	logic        count_ok;
	logic        wr_en;
	logic        rd_en;
	logic        addr_ok;
	logic [7:0]  ctrl_rd;
	logic [7:0]  gate_rd;

	tcg_sync i_tcg_sync (
		.sys_clk (sys_clk),
		.reset   (reset),
		.din     (ext_clk_in),
		.dout    (ext_synced)
	);

	assign internal_src = (clock_source_select_q == tcg_pkg::TCG_SRC_FOSC) ||
		(clock_source_select_q == tcg_pkg::TCG_SRC_FOSC_DIV4);

	// Internal sources hold the level high, ticks come from internal_tick; no synchronizer stage added
	// External source: bypass takes raw pin, else the resynced copy
	always_comb begin
		if (internal_src) begin
			timer_clock_source = 1'b1;
		end else if (ctrl_q.ext_sync_bypass) begin
			timer_clock_source = ext_clk_in;
		end else begin
			timer_clock_source = ext_synced;
		end
	end

	// Fosc/4 is a one-cycle enable every fourth sys_clk from a divider
	always_comb begin
		qdiv_d = qdiv_q + 2'h1;
	end

	// The divider runs freely, so a source switch may land mid-quarter
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			qdiv_q <= 2'h0;
		end else begin
			qdiv_q <= qdiv_d;
		end
	end

	assign internal_tick = (clock_source_select_q == tcg_pkg::TCG_SRC_FOSC) ||
		(&qdiv_q);

	// Internal sources count on their enable; external on rising edge
	assign src_edge = internal_src ? internal_tick : (timer_clock_source & ~tick_prev_q);

	// Divider of 1, 2, 4 or 8 by field value
	always_comb begin
		ps_d = ps_q;
		inc_edge = 1'b0;
		if (!ctrl_q.count_enable) begin
			ps_d = '0;
		end else if (src_edge) begin
			case (ctrl_q.input_prescale_select)
				2'h0: inc_edge = 1'b1;
				2'h1: inc_edge = ps_q[0];
				2'h2: inc_edge = &ps_q[1:0];
				2'h3: inc_edge = &ps_q[2:0];
				default: inc_edge = 1'b1;
			endcase
			ps_d = ps_q + {{(PS_W-1){1'b0}}, 1'b1};
		end
	end

	// Gate path: polarity, toggle, single pulse
	assign gate_pol  = gate_q.gate_polarity ? gate_in : ~gate_in;
	assign gate_rise = gate_pol & ~gate_prev_q;

	always_comb begin
		tog_d = tog_q;
		if (!ctrl_q.count_enable || !gate_q.gate_toggle_mode) begin
			tog_d = 1'b0;
		end else if (gate_rise) begin
			tog_d = ~tog_q;
		end
	end

	logic tm_level;
	assign tm_level = gate_q.gate_toggle_mode ? tog_q : gate_pol;

	// Single pulse: window opens on the armed rising level, closes on fall
	always_comb begin
		pulse_open_d = pulse_open_q;
		if (!gate_q.gate_single_pulse_mode || !gate_q.pulse_arm_status) begin
			pulse_open_d = 1'b0;
		end else if (tm_level && !pulse_prev_q) begin
			pulse_open_d = 1'b1;
		end
	end

	assign gate_ctrl = gate_q.gate_single_pulse_mode ? (pulse_open_q & tm_level) : tm_level;
	assign gate_level = gate_ctrl;
	assign count_ok  = ctrl_q.count_enable &&
		(!gate_q.gate_enable || gate_ctrl);

	// APB slave, zero wait states
	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & penable & ~pwrite;
	assign pready  = 1'b1;
	assign addr_ok = (paddr == tcg_pkg::TCG_ADDR_CTRL) || (paddr == tcg_pkg::TCG_ADDR_GATE) ||
		(paddr == tcg_pkg::TCG_ADDR_CLKSEL) || (paddr == tcg_pkg::TCG_ADDR_CNT_LO) ||
		(paddr == tcg_pkg::TCG_ADDR_CNT_HI);
	assign pslverr = psel & penable & ~addr_ok;

	// Unimplemented positions are simply never stored
	assign ctrl_rd = {2'h0, ctrl_q.input_prescale_select, 1'b0, ctrl_q.ext_sync_bypass,
		ctrl_q.wide_read_mode, ctrl_q.count_enable};
	assign gate_rd = {gate_q.gate_enable, gate_q.gate_polarity, gate_q.gate_toggle_mode,
		gate_q.gate_single_pulse_mode, gate_q.pulse_arm_status, gate_ctrl, 2'h0};

	always_comb begin
		ctrl_d = ctrl_q;
		gate_d = gate_q;
		clock_source_select_d = clock_source_select_q;
		cnt_d = cnt_q;
		hi_buf_d = hi_buf_q;
		rdata_d = rdata_q;
		if (count_ok && inc_edge) begin
			cnt_d = cnt_q + 16'h0001;
		end
		// A pulse that ends clears the arm bit
		if (pulse_open_q && !gate_ctrl) begin
			gate_d.pulse_arm_status = 1'b0;
		end
		if (wr_en && pstrb[0]) begin
			case (paddr)
				tcg_pkg::TCG_ADDR_CTRL: begin
					ctrl_d.input_prescale_select = pwdata[tcg_pkg::TCG_CTRL_PS_LSB +: 2];
					ctrl_d.ext_sync_bypass = pwdata[tcg_pkg::TCG_CTRL_SYNC_BIT];
					ctrl_d.wide_read_mode = pwdata[tcg_pkg::TCG_CTRL_WIDE_READ_MODE_BIT];
					ctrl_d.count_enable = pwdata[tcg_pkg::TCG_CTRL_ON_BIT];
				end
				tcg_pkg::TCG_ADDR_GATE: begin
					gate_d.gate_enable = pwdata[tcg_pkg::TCG_GATE_EN_BIT];
					gate_d.gate_polarity = pwdata[tcg_pkg::TCG_GATE_POL_BIT];
					gate_d.gate_toggle_mode = pwdata[tcg_pkg::TCG_GATE_TM_BIT];
					gate_d.gate_single_pulse_mode = pwdata[tcg_pkg::TCG_GATE_SPM_BIT];
					gate_d.pulse_arm_status = pwdata[tcg_pkg::TCG_GATE_ARM_BIT];
				end
				tcg_pkg::TCG_ADDR_CLKSEL: clock_source_select_d = pwdata[1:0];
				tcg_pkg::TCG_ADDR_CNT_LO: cnt_d[7:0] = pwdata[7:0];
				tcg_pkg::TCG_ADDR_CNT_HI: cnt_d[15:8] = pwdata[7:0];
				default: ;
			endcase
		end
		if (!gate_d.gate_single_pulse_mode) begin
			gate_d.pulse_arm_status = 1'b0;
		end
		if (rd_en) begin
			case (paddr)
				tcg_pkg::TCG_ADDR_CTRL: rdata_d = {24'h0, ctrl_rd};
				tcg_pkg::TCG_ADDR_GATE: rdata_d = {24'h0, gate_rd};
				tcg_pkg::TCG_ADDR_CLKSEL: rdata_d = {30'h0, clock_source_select_q};
				tcg_pkg::TCG_ADDR_CNT_LO: begin
					rdata_d = {24'h0, cnt_q[7:0]};
					hi_buf_d = cnt_q[15:8];
				end
				tcg_pkg::TCG_ADDR_CNT_HI: begin
					rdata_d = {24'h0, ctrl_q.wide_read_mode ? hi_buf_q : cnt_q[15:8]};
				end
				default: rdata_d = 32'h0;
			endcase
		end
	end

	// Edge history of the source clock, the gate and the window level
	always_comb begin
		tick_prev_d = timer_clock_source;
		gate_prev_d = gate_pol;
		pulse_prev_d = tm_level;
	end

	// Only POR/BOR reaches this reset; other resets leave registers alone
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ctrl_q <= tcg_pkg::tcg_ctrl_t'(5'h00);
			gate_q <= tcg_pkg::tcg_gate_t'(5'h00);
			clock_source_select_q <= 2'h0;
			cnt_q <= 16'h0000;
			hi_buf_q <= 8'h00;
			rdata_q <= 32'h0;
		end else begin
			ctrl_q <= ctrl_d;
			gate_q <= gate_d;
			clock_source_select_q <= clock_source_select_d;
			cnt_q <= cnt_d;
			hi_buf_q <= hi_buf_d;
			rdata_q <= rdata_d;
		end
	end

	// Prescaler restarts from zero whenever the timer is switched off
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ps_q <= '0;
		end else begin
			ps_q <= ps_d;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			tog_q <= 1'b0;
		end else begin
			tog_q <= tog_d;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pulse_open_q <= 1'b0;
		end else begin
			pulse_open_q <= pulse_open_d;
		end
	end

	// Gate history may show a rise right after reset; toggle mode is off then
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			tick_prev_q <= 1'b0;
			gate_prev_q <= 1'b0;
			pulse_prev_q <= 1'b0;
		end else begin
			tick_prev_q <= tick_prev_d;
			gate_prev_q <= gate_prev_d;
			pulse_prev_q <= pulse_prev_d;
		end
	end

	// Read data is registered, but during a read access prdata is the zero-wait combinational mux
	assign prdata = rd_en ? rdata_d : rdata_q;
	assign count_value = cnt_q;
endmodule

// ===== dv/tcg_top_asserts.sv
`timescale 1ns/1ps
module tcg_top_asserts (
	input wire logic        sys_clk,     // Clock
	input wire logic        reset,       // Reset
	input wire logic        psel,        // Select
	input wire logic        penable,     // Enable
	input wire logic        pwrite,      // Direction
	input wire logic [11:0] paddr,       // Address
	input wire logic [31:0] pwdata,      // Write data
	input wire logic [3:0]  pstrb,       // Strobes
	input wire logic [31:0] prdata,      // Read data
	input wire logic        pready,      // Ready
	input wire logic        pslverr,     // Error
	input wire logic        ext_clk_in,  // Ext clock
	input wire logic        gate_in,     // Gate
	input wire logic [15:0] count_value, // Count
	input wire logic        gate_level   // Gate level
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	logic acc;
	logic rd;
	logic hit;
	logic en_q;
	assign acc = psel && penable;
	assign rd = acc && !pwrite;
	assign hit = paddr <= tcg_pkg::TCG_ADDR_CNT_HI && paddr[1:0] == 2'h0;
	// Mirror of the enable bit, so counter stillness can be judged from the bus alone
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) en_q <= 1'b0;
		else if (acc && pwrite && pstrb[0] && paddr == tcg_pkg::TCG_ADDR_CTRL) en_q <= pwdata[0];
	end
	rdy_access_a: assert property (acc |-> pready) else $error("pready low in access");
	err_unmap_a: assert property (acc && !hit |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	err_map_a: assert property (acc && hit |-> !pslverr) else $error("mapped access refused");
	ctrl_zero_a: assert property (rd && paddr == tcg_pkg::TCG_ADDR_CTRL |->
		(prdata & ~32'h37) == 32'h0) else $error("control spare bits not zero");
	gate_zero_a: assert property (rd && paddr == tcg_pkg::TCG_ADDR_GATE |->
		prdata[31:8] == 24'h0 && prdata[1:0] == 2'h0) else $error("gate spare bits not zero");
	level_read_a: assert property (rd && paddr == tcg_pkg::TCG_ADDR_GATE |->
		prdata[2] == gate_level) else $error("gate level read mismatch");
	stop_hold_a: assert property (!en_q && !(acc && pwrite) |=> $stable(count_value))
		else $error("count moved while stopped");
	reset_val_a: assert property ($fell(reset) |-> count_value == 16'h0)
		else $error("count not zero after reset");
	cover property (rd && paddr == tcg_pkg::TCG_ADDR_CNT_HI);
	cover property (en_q && $changed(count_value));
	cover property (acc && !hit);
endmodule
bind tcg_top tcg_top_asserts i_tcg_top_asserts (.sys_clk(sys_clk), .reset(reset), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clk_in(ext_clk_in),
	.gate_in(gate_in), .count_value(count_value), .gate_level(gate_level));

// ===== dv/test_tcg_top.sv
`timescale 1ns/1ps
module test_tcg_top;
	localparam logic [11:0] A_CT = tcg_pkg::TCG_ADDR_CTRL;
	localparam logic [11:0] A_GT = tcg_pkg::TCG_ADDR_GATE;
	localparam logic [11:0] A_CS = tcg_pkg::TCG_ADDR_CLKSEL;
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        ext_clk_in = 1'b0;
	logic        gate_in = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'hF;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        gate_level;
	logic [15:0] count_value;
	logic [15:0] c0;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [7:0]  r;
	int          n_fail = 0;
	int          n_compared = 0;
	tcg_top i_tcg_top (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_clk_in(ext_clk_in), .gate_in(gate_in),
		.count_value(count_value), .gate_level(gate_level));
	initial forever #5 sys_clk = ~sys_clk;
	task check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		n_compared++;
		if (seen !== ex) begin
			n_fail++;
			$display("[FAIL] %s exp %h seen %h", nm, ex, seen);
		end
	endtask
	task stop_test;
		if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Reads note d as the expected value under mask m
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
		if (!w) begin
			exp_q.push_back(d);
			msk_q.push_back(m);
		end
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task pulse(input logic ext);
		if (ext) ext_clk_in <= 1'b1; else gate_in <= 1'b1;
		wt(4);
		if (ext) ext_clk_in <= 1'b0; else gate_in <= 1'b0;
		wt(4);
	endtask
	// Reads are judged half a cycle into the access, where prdata has settled
	always @(negedge sys_clk) begin
		if (psel && penable && !pwrite && pready === 1'b1) begin
			check("prdata", prdata & msk_q.pop_front(), exp_q.pop_front());
		end
	end
	initial begin
		void'($urandom(87261));
		wt(10);
		reset <= 1'b0;
		wt(1);
		for (int i = 0; i < 8; i++) begin
			r = 8'($urandom);
			apb(1, A_CT, {24'h0, r}, 0);
			apb(0, A_CT, {24'h0, r & tcg_pkg::TCG_CTRL_MASK}, 32'hFFFFFFFF);
		end
		apb(1, A_GT, 32'hE0, 0);
		reset <= 1'b1;
		wt(2);
		reset <= 1'b0;
		wt(1);
		apb(0, A_CT, 0, 32'hFFFFFFFF);
		apb(0, A_GT, 0, 32'hFFFFFFFB);
		pstrb <= 4'h0;
		apb(1, A_CT, 32'h37, 0);
		pstrb <= 4'hF;
		apb(0, A_CT, 0, 32'hFFFFFFFF);
		apb(0, 12'h014, 0, 32'hFFFFFFFF);
		apb(1, A_GT, 32'h58, 0);
		apb(0, A_GT, 32'h18, 32'h18);
		apb(1, A_GT, 32'h48, 0);
		apb(0, A_GT, 0, 32'h18);
		for (int i = 0; i < 4; i++) begin
			gate_in <= i[0];
			apb(1, A_GT, {24'h0, 1'b1, i[1], 6'h0}, 0);
			wt(8);
			apb(0, A_GT, {29'h0, ~(i[0] ^ i[1]), 2'h0}, 32'h4);
		end
		// Gate must idle low so the first pulse is a real rise
		gate_in <= 1'b0;
		apb(1, A_CT, 1, 0);
		apb(1, A_GT, 32'hE0, 0);
		pulse(0);
		apb(0, A_GT, 4, 4);
		pulse(0);
		apb(0, A_GT, 0, 4);
		pulse(0);
		apb(1, A_GT, 32'hC0, 0);
		apb(1, A_GT, 32'hE0, 0);
		apb(0, A_GT, 0, 4);
		pulse(0);
		apb(1, A_CT, 0, 0);
		apb(0, A_GT, 0, 4);
		apb(1, A_GT, 0, 0);
		for (int s = 1; s < 3; s++) begin
			apb(1, A_CS, s, 0);
			for (int p = 0; p < 4; p++) begin
				apb(1, A_CT, (p << 4) | 5, 0);
				wt(4);
				@(negedge sys_clk) c0 = count_value;
				repeat (64) @(negedge sys_clk);
				check("count", count_value - c0, (s == 1 ? 16 : 64) >> p);
			end
		end
		apb(1, A_CT, 0, 0);
		c0 = count_value;
		wt(64);
		check("stopped", count_value - c0, 0);
		apb(1, A_CS, 0, 0);
		for (int s = 0; s < 2; s++) begin
			apb(1, A_CT, (s << 2) | 1, 0);
			wt(4);
			c0 = count_value;
			repeat (20) pulse(1);
			wt(8);
			check("ext count", count_value - c0, 20);
			// Bypass counts one edge after the rise, the resync path two later
			c0 = count_value;
			ext_clk_in <= 1'b1;
			wt(1);
			@(negedge sys_clk) check("sync stage", count_value - c0, s);
			wt(8);
			ext_clk_in <= 1'b0;
			wt(8);
		end
		apb(1, A_CS, 2, 0);
		apb(1, A_CT, 2, 0);
		apb(1, tcg_pkg::TCG_ADDR_CNT_LO, 32'hF0, 0);
		apb(1, tcg_pkg::TCG_ADDR_CNT_HI, 32'h12, 0);
		apb(0, tcg_pkg::TCG_ADDR_CNT_LO, 32'hF0, 32'hFF);
		apb(1, A_CT, 3, 0);
		wt(300);
		apb(0, tcg_pkg::TCG_ADDR_CNT_HI, 32'h12, 32'hFF);
		apb(1, A_CT, 0, 0);
		apb(0, tcg_pkg::TCG_ADDR_CNT_HI, 32'h14, 32'hFF);
		stop_test;
	end
	initial begin
		wt(20000);
		n_fail++;
		stop_test;
	end
endmodule
